/* File: shared/buck_seq_pkg.sv */
package buck_seq_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_KHZ = 25_000;
  localparam int FSW_LOW_HZ = 400_000;
  localparam int FSW_HIGH_HZ = 1_500_000;
  localparam int SS_LOW_US = 2500;
  localparam int SS_HIGH_US = 3500;
  localparam int HIC_LOW_US = 25000;
  localparam int HIC_HIGH_US = 35000;
  localparam int TON_MIN_NS = 36;

  localparam int TIMER_W = 20;
  localparam logic [19:0] SS_LOW_CYC_DEF = 20'(SS_LOW_US * CLK_KHZ / 1000);
  localparam logic [19:0] SS_HIGH_CYC_DEF = 20'(SS_HIGH_US * CLK_KHZ / 1000);
  localparam logic [19:0] HIC_LOW_CYC_DEF = 20'(HIC_LOW_US * CLK_KHZ / 1000);
  localparam logic [19:0] HIC_HIGH_CYC_DEF = 20'(HIC_HIGH_US * CLK_KHZ / 1000);
  localparam logic [6:0] PER_LOW_CYC = 7'(CLK_KHZ * 1000 / FSW_LOW_HZ);
  localparam logic [6:0] PER_HIGH_CYC = 7'(CLK_KHZ * 1000 / FSW_HIGH_HZ);
  // Least time, so round up, and never below one cycle
  localparam int TON_RAW = (TON_MIN_NS * CLK_KHZ + 999_999) / 1_000_000;
  localparam logic [6:0] TON_MIN_CYC = 7'((TON_RAW < 1) ? 1 : TON_RAW);
  // Missing external clock: two of the longest internal periods
  localparam logic [7:0] SYNC_GAP_CYC = 8'(2 * PER_LOW_CYC);
  localparam logic [1:0] LOCK_EDGES = 2'h2;

  // ==========================================================
  // Register map (byte addresses) and bus answers
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_HICCUPS = 8'h08;
  localparam int CTRL_FREQ_HIGH_BIT = 0;
  localparam logic CTRL_FREQ_HIGH_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_OFF, ST_BIAS_WAIT, ST_SOFT_START, ST_RUN, ST_HICCUP, ST_THERMAL
  } seq_state_t;

  // Asynchronous inputs: pins and analog comparators
  typedef struct packed {
    logic en;
    logic mode_sync;
    logic phase_in;
    logic bias_ok;
    logic cur_limit;
    logic out_low_quarter;
    logic over_temp;
    logic temp_cooled;
    logic out_above_2v5;
    logic out_below_1v8;
    logic out_in_window;
    logic loop_end_on;
    logic light_load;
  } sense_in_t;

  localparam int SENSE_W = $bits(sense_in_t);

  // Power stage and analog control outputs
  typedef struct packed {
    logic bias_reg_en;
    logic bias_from_output;
    logic hs_on;
    logic ls_on;
    logic switch_node_hiz;
    logic ss_ramp_active;
    logic shared_node_drive;
    logic shared_node_as_input;
  } drive_out_t;

  typedef struct packed {
    logic [SENSE_W-1:0] s1;
    logic [SENSE_W-1:0] s2;
    logic [SENSE_W-1:0] s3;
    logic [SENSE_W-1:0] f;
  } filt_regs_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } axi_regs_t;

  typedef struct packed {
    seq_state_t state;
    logic target;
    logic freq_high;
    logic [19:0] timer;
    logic [6:0] cnt;
    logic [6:0] on_cnt;
    logic hs;
    logic ls;
    logic in_limit;
    logic sync_prev;
    logic [1:0] edge_cnt;
    logic [7:0] gap_cnt;
    logic phase_clk;
    logic pg_low;
    logic [15:0] hiccups;
    axi_regs_t axi;
  } seq_regs_t;

endpackage

/* File: rtl/pin_filter.sv */
`timescale 1ns/10ps
module pin_filter
  import buck_seq_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Raw and filtered levels
  input wire sense_in_t raw_in,
  output sense_in_t clean_out
);

  filt_regs_t q, d;
  logic [SENSE_W-1:0] agree;

  // =========================================================
  // Per bit: a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < SENSE_W; i++) begin : g_bit
      assign agree[i] = (q.s2[i] == q.s3[i]) ? q.s2[i] : q.f[i];
    end
  endgenerate

  // Stage one feeds only stage two, so metastability stays contained
  always_comb begin
    d = q;
    d.s1 = raw_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f = agree;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign clean_out = sense_in_t'(q.f);

endmodule

/* File: rtl/buck_sequencer.sv */
`timescale 1ns/10ps
// What this block does
// R1 - Low enable: shutdown, bias regulator and both gate drivers off.
// R2 - After enable, stay idle until internal supply clears lockout, then ramp.
// R3 - Soft-start lasts 2.5ms at low frequency, 3.5ms at high frequency.
// R4 - Switch at fixed internal 400kHz or 1.5MHz per selected variant.
// R5 - Mode input low gives pulse skipping; high or clocked gives forced fixed frequency.
// R6 - With external clock, each switching period starts at its rising edge.
// R7 - Lock onto an applied external clock within two of its cycles.
// R8 - No external edge for over two periods: fall back to internal oscillator.
// R9 - High-side on-time never shorter than the 36ns minimum.
// R10 - Overload: high side until limit trips, low side until below, repeat.
// R11 - Hard short flagged when output under quarter target while current limiting.
// R12 - Hard short: stop 35ms or 25ms, then soft-start again, indefinitely.
// R13 - Hard-short detection and hiccup inhibited during soft-start.
// R14 - Over-temperature stops converter; restart only after 15C cooling.
// R15 - While off, switch node high impedance with both switches open.
// R16 - Bias from input at startup; from output only above 2.5V, never below 1.8V.
// R17 - On enable rise: target if phase clock pin tied high, else controller.
// R18 - Controller drives phase clock 180 degrees from its switching clock; code counts half the internal period, even when locked externally.
// R19 - In pulse skipping, phase clock output stays quiet.
// R20 - Controller drives shared error node; target takes it as current command.
// R21 - System uses two phases only in forced mode; may disable target.
// R22 - Power-ok output open-drain: pulls low only, external pull-up.
// R23 - Low enable aborts any state immediately back to shutdown.
// R24 - Enable, mode and role inputs pass a synchroniser before use.
module buck_sequencer
  import buck_seq_pkg::*;
#(
  parameter logic [19:0] SS_LOW_CYC = SS_LOW_CYC_DEF,
  parameter logic [19:0] SS_HIGH_CYC = SS_HIGH_CYC_DEF,
  parameter logic [19:0] HIC_LOW_CYC = HIC_LOW_CYC_DEF,
  parameter logic [19:0] HIC_HIGH_CYC = HIC_HIGH_CYC_DEF
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Pins and comparators, asynchronous
  input wire sense_in_t sense_pins_in,
  // Power stage controls
  output drive_out_t drive_out,
  // Phase clock pin, two-way
  output logic phase_clock_out_o,
  output logic phase_clock_out_oe,
  // Power-ok pin, open drain
  output logic power_ok_out_o,
  output logic power_ok_out_oe
);

  seq_regs_t q, d;
  sense_in_t s;

  // =========================================================
  // Input conditioning
  pin_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .raw_in(sense_pins_in), // R24
    .clean_out(s)
  );

  // =========================================================
  // Next-state logic
  always_comb begin
    logic [6:0] per;
    logic [19:0] ss_cyc;
    logic [19:0] hic_cyc;
    logic ext_edge;
    logic clk_present;
    logic locked;
    logic skip_mode;
    logic period_start;
    logic active;
    logic hard_short;
    logic [7:0] a;
    per = q.freq_high ? PER_HIGH_CYC : PER_LOW_CYC; // R4
    ss_cyc = q.freq_high ? SS_HIGH_CYC : SS_LOW_CYC; // R3
    hic_cyc = q.freq_high ? HIC_HIGH_CYC : HIC_LOW_CYC; // R12
    ext_edge = s.mode_sync & ~q.sync_prev;
    clk_present = (q.edge_cnt != 2'h0);
    locked = (q.edge_cnt == LOCK_EDGES); // R7
    skip_mode = ~s.mode_sync & ~clk_present; // R5
    period_start = locked ? ext_edge : (q.cnt >= per - 7'h1); // R6
    active = (q.state == ST_SOFT_START) || (q.state == ST_RUN);
    hard_short = q.in_limit & s.out_low_quarter; // R11
    a = 8'h00;
    d = q;

    // External clock watch: edges counted up to lock, cleared on a long gap
    d.sync_prev = s.mode_sync;
    if (ext_edge) begin
      d.gap_cnt = 8'h00;
      if (!locked) begin
        d.edge_cnt = q.edge_cnt + 2'h1;
      end
    end else if (q.gap_cnt >= SYNC_GAP_CYC) begin
      d.edge_cnt = 2'h0; // R8
    end else begin
      d.gap_cnt = q.gap_cnt + 8'h01;
    end

    // Period counter; saturates while waiting for a slow external edge
    if (period_start) begin
      d.cnt = 7'h00;
    end else if (q.cnt != 7'h7f) begin
      d.cnt = q.cnt + 7'h01;
    end

    // Power switch sequencing, one period at a time
    if (!active) begin
      d.hs = 1'b0; // R15
      d.ls = 1'b0; // R15
      d.in_limit = 1'b0;
    end else if (period_start) begin
      d.in_limit = 1'b0;
      d.on_cnt = 7'h00;
      d.hs = ~(skip_mode & s.light_load); // R5
      d.ls = 1'b0;
    end else if (q.hs) begin
      if (q.on_cnt != 7'h7f) begin
        d.on_cnt = q.on_cnt + 7'h01;
      end
      if (s.cur_limit) begin
        d.hs = 1'b0; // R10
        d.ls = 1'b1; // R10
        d.in_limit = 1'b1;
      end else if (s.loop_end_on && (q.on_cnt >= TON_MIN_CYC - 7'h1)) begin
        d.hs = 1'b0; // R9
        d.ls = 1'b1;
      end
    end else if (q.in_limit && q.ls && !s.cur_limit) begin
      d.hs = 1'b1; // R10
      d.ls = 1'b0;
      d.on_cnt = 7'h00;
    end

    // Phase clock: high once the period count reaches half the internal period
    d.phase_clk = active & ~skip_mode & ~q.target & (q.cnt >= (per >> 1)); // R18 R19
    d.pg_low = ~((q.state == ST_RUN) & s.out_in_window); // R22

    // Sequencer; a low enable wins over everything
    d.timer = q.timer + 20'h00001;
    if (!s.en) begin
      d.state = ST_OFF; // R1 R23
      d.hs = 1'b0;
      d.ls = 1'b0;
      d.phase_clk = 1'b0;
    end else begin
      case (q.state)
        ST_OFF: begin
          d.target = s.phase_in; // R17
          d.state = ST_BIAS_WAIT;
        end
        ST_BIAS_WAIT: begin
          if (s.over_temp) begin
            d.state = ST_THERMAL; // R14
          end else if (s.bias_ok) begin
            d.state = ST_SOFT_START; // R2
            d.timer = 20'h00000;
          end
        end
        ST_SOFT_START: begin
          if (s.over_temp) begin
            d.state = ST_THERMAL; // R14
          end else if (!s.bias_ok) begin
            d.state = ST_BIAS_WAIT;
          end else if (q.timer >= ss_cyc - 20'h00001) begin
            d.state = ST_RUN; // R3 R13
          end
        end
        ST_RUN: begin
          if (s.over_temp) begin
            d.state = ST_THERMAL; // R14
          end else if (!s.bias_ok) begin
            d.state = ST_BIAS_WAIT;
          end else if (hard_short) begin
            d.state = ST_HICCUP; // R11 R13
            d.timer = 20'h00000;
            d.hiccups = q.hiccups + 16'h0001;
            d.hs = 1'b0;
            d.ls = 1'b0;
          end
        end
        ST_HICCUP: begin
          if (s.over_temp) begin
            d.state = ST_THERMAL;
          end else if (q.timer >= hic_cyc - 20'h00001) begin
            d.state = ST_SOFT_START; // R12
            d.timer = 20'h00000;
          end
        end
        ST_THERMAL: begin
          // The sensor reports the cooled state once it has fallen by the hysteresis
          if (s.temp_cooled && !s.over_temp) begin
            d.state = ST_SOFT_START; // R14
            d.timer = 20'h00000;
          end
        end
        default: begin
          d.state = ST_OFF;
        end
      endcase
    end

    // AXI4-Lite write side: address and data taken in either order
    if (q.axi.bvalid && bready) begin
      d.axi.bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      d.axi.aw_got = 1'b1;
      d.axi.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      d.axi.w_got = 1'b1;
      d.axi.wdata = wdata[7:0];
      d.axi.wstrb0 = wstrb[0];
    end
    if (q.axi.aw_got && q.axi.w_got && !q.axi.bvalid) begin
      d.axi.aw_got = 1'b0;
      d.axi.w_got = 1'b0;
      d.axi.bvalid = 1'b1;
      d.axi.bresp = RESP_OKAY;
      a = {q.axi.awaddr[7:2], 2'h0};
      if (a == ADDR_CTRL) begin
        if (q.axi.wstrb0) begin
          d.freq_high = q.axi.wdata[CTRL_FREQ_HIGH_BIT];
        end
      end else if (a == ADDR_STATUS || a == ADDR_HICCUPS) begin
        d.axi.bresp = RESP_OKAY; // Read-only, write ignored
      end else begin
        d.axi.bresp = RESP_SLVERR;
      end
    end

    // AXI4-Lite read side
    if (q.axi.rvalid && rready) begin
      d.axi.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.axi.rvalid = 1'b1;
      d.axi.rresp = RESP_OKAY;
      a = {araddr[7:2], 2'h0};
      if (a == ADDR_CTRL) begin
        d.axi.rdata = {31'h00000000, q.freq_high};
      end else if (a == ADDR_STATUS) begin
        d.axi.rdata = {23'h000000, q.in_limit, q.ls, q.hs, skip_mode, locked,
                       q.target, q.state};
      end else if (a == ADDR_HICCUPS) begin
        d.axi.rdata = {16'h0000, q.hiccups};
      end else begin
        d.axi.rdata = 32'h00000000;
        d.axi.rresp = RESP_SLVERR;
      end
    end
  end

  // =========================================================
  // State register; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.state <= ST_OFF;
      q.freq_high <= CTRL_FREQ_HIGH_RST;
      q.pg_low <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // =========================================================
  // Bus handshakes; one write and one read in flight at most
  assign awready = ~q.axi.aw_got & ~q.axi.bvalid;
  assign wready = ~q.axi.w_got & ~q.axi.bvalid;
  assign bvalid = q.axi.bvalid;
  assign bresp = q.axi.bresp;
  assign arready = ~q.axi.rvalid;
  assign rvalid = q.axi.rvalid;
  assign rdata = q.axi.rdata;
  assign rresp = q.axi.rresp;

  // =========================================================
  // Power stage and pins, all from flip-flops
  always_comb begin
    drive_out.bias_reg_en = (q.state != ST_OFF); // R1
    // Hand over to the output only once running and output is high enough
    drive_out.bias_from_output = (q.state == ST_RUN) & s.out_above_2v5 &
                                 ~s.out_below_1v8; // R16
    drive_out.hs_on = q.hs;
    drive_out.ls_on = q.ls;
    drive_out.switch_node_hiz = ~q.hs & ~q.ls; // R15
    drive_out.ss_ramp_active = (q.state == ST_SOFT_START);
    drive_out.shared_node_drive = ~q.target & (q.state != ST_OFF); // R20
    drive_out.shared_node_as_input = q.target & (q.state != ST_OFF); // R20
  end

  // A target never drives its phase pin; it is strapped high by the board
  assign phase_clock_out_o = q.phase_clk; // R18
  assign phase_clock_out_oe = ~q.target & (q.state != ST_OFF); // R17
  assign power_ok_out_o = 1'b0; // R22
  assign power_ok_out_oe = q.pg_low; // R22

endmodule

/* File: verif/buck_seq_props.sv */
`timescale 1ns/10ps
module buck_seq_props
  import buck_seq_pkg::*;
#(
  parameter logic [19:0] SS_HIGH_CYC = SS_HIGH_CYC_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Pins
  input wire sense_in_t sense_pins_in,
  input wire drive_out_t drive_out,
  input wire logic phase_clock_out_o,
  input wire logic power_ok_out_o
);
  logic [7:0] quiet_q;
  logic [7:0] quiet_d;
  logic [19:0] ramp_q;
  logic [19:0] ramp_d;
  // ==========================================================
  // Helper counters; quiet saturates so a long skip never wraps
  always_comb begin
    quiet_d = (sense_pins_in.mode_sync || !ce) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
    ramp_d = drive_out.ss_ramp_active ? ramp_q + {19'h00000, ce} : 20'h00000;
  end
  // Counters follow the sync reset like the design
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quiet_q <= 8'h00;
      ramp_q <= 20'h00000;
    end else begin
      quiet_q <= quiet_d;
      ramp_q <= ramp_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Steps seen at the inputs
  sequence s_en_low; (!sense_pins_in.en && ce) [*7]; endsequence
  sequence s_bias_low; (!sense_pins_in.bias_ok && ce) [*7]; endsequence
  sequence s_hot; (sense_pins_in.over_temp && ce) [*7]; endsequence
  sequence s_en_rise; (!sense_pins_in.en && !drive_out.bias_reg_en && ce) ##1 sense_pins_in.en; endsequence
  property p_off; s_en_low |-> !drive_out.bias_reg_en && !drive_out.hs_on && !drive_out.ls_on
    && drive_out.switch_node_hiz; endproperty
  a_off: assert property (p_off) else $error("active with enable low");
  property p_wait; s_bias_low |-> !drive_out.ss_ramp_active && !drive_out.hs_on
    && !drive_out.ls_on; endproperty
  a_wait: assert property (p_wait) else $error("ramp without supply");
  property p_sync; s_en_rise |-> !drive_out.bias_reg_en [*3]; endproperty
  a_sync: assert property (p_sync) else $error("enable used unsynchronised");
  property p_ramp; drive_out.ss_ramp_active |-> ramp_q <= SS_HIGH_CYC; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp too long");
  property p_excl; !(drive_out.hs_on && drive_out.ls_on); endproperty
  a_excl: assert property (p_excl) else $error("both switches on");
  property p_hiz; !drive_out.bias_reg_en |-> drive_out.switch_node_hiz; endproperty
  a_hiz: assert property (p_hiz) else $error("switch closed while off");
  property p_hot; s_hot |-> !drive_out.hs_on && !drive_out.ls_on
    && !drive_out.ss_ramp_active; endproperty
  a_hot: assert property (p_hot) else $error("running while hot");
  property p_quiet; quiet_q >= 8'ha0 |-> !phase_clock_out_o; endproperty
  a_quiet: assert property (p_quiet) else $error("phase clock in skip");
  property p_node; !(drive_out.shared_node_drive && drive_out.shared_node_as_input); endproperty
  a_node: assert property (p_node) else $error("shared node both ways");
  property p_pok; !power_ok_out_o; endproperty
  a_pok: assert property (p_pok) else $error("power ok driven high");
endmodule
bind buck_sequencer buck_seq_props #(
  .SS_HIGH_CYC(SS_HIGH_CYC)
) u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .ce(ce),
  .sense_pins_in(sense_pins_in),
  .drive_out(drive_out),
  .phase_clock_out_o(phase_clock_out_o),
  .power_ok_out_o(power_ok_out_o)
);

/* File: verif/sync_partner.sv */
`timescale 1ns/10ps
module sync_partner (
  // Bench control
  input wire logic run,
  input wire logic level,
  input wire logic tie_target,
  // Phase pin from the device
  input wire logic phase_o,
  input wire logic phase_oe,
  // Lines to the device
  output logic mode_sync,
  output logic phase_in
);
  logic clk_q = 1'b0;
  // 320 ns clock with a phase unrelated to the bench; stands low between frames
  initial begin
    #7;
    forever begin
      #160;
      clk_q = run ? ~clk_q : 1'b0;
    end
  end
  // A tied pair is always in forced mode
  assign mode_sync = run ? clk_q : (level | tie_target);
  // Only a target is tied high; an open pin reads low
  assign phase_in = tie_target ? 1'b1 : (phase_oe & phase_o);
endmodule

/* File: verif/buck_mode_and_protection_sequencer_tb.sv */
`timescale 1ns/10ps
module buck_mode_and_protection_sequencer_tb;
  import buck_seq_pkg::*;
  // ==========================================================
  // Short counts keep the run brief
  localparam logic [19:0] SSL = 20'h000c8;
  localparam logic [19:0] SSH = 20'h0012c;
  localparam logic [19:0] HIL = 20'h00190;
  localparam logic [19:0] HIH = 20'h001f4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, pco, pcoe, poko, pokoe, msync, phin;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  sense_in_t sn = '0;
  sense_in_t sp;
  drive_out_t drv;
  logic run = 1'b0;
  logic tie = 1'b0;
  int err_total = 0;
  int n_tests = 0;
  int m_st, per, h, f;
  // Partner supplies the mode and phase lines
  always_comb begin
    sp = sn;
    sp.mode_sync = msync;
    sp.phase_in = phin;
  end
  sync_partner PEER (.run(run), .level(sn.mode_sync), .tie_target(tie), .phase_o(pco),
    .phase_oe(pcoe), .mode_sync(msync), .phase_in(phin));
  buck_sequencer #(.SS_LOW_CYC(SSL), .SS_HIGH_CYC(SSH), .HIC_LOW_CYC(HIL),
    .HIC_HIGH_CYC(HIH)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .sense_pins_in(sp), .drive_out(drv), .phase_clock_out_o(pco),
    .phase_clock_out_oe(pcoe), .power_ok_out_o(poko), .power_ok_out_oe(pokoe));
  // 25 MHz
  always #20 aclk = ~aclk;
  // ==========================================================
  // Checking and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Handshakes are judged before the edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int k;
    cyc(1 + $urandom_range(2));
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (k = 0; k < 50 && !tb; k++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(tb, 1'b1, "write answer");
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    int k;
    cyc(1 + $urandom_range(2));
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tv = 1'b0;
    for (k = 0; k < 50 && !tv; k++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tv = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(tv, 1'b1, "read answer");
  endtask
  // Model state against the state field
  task automatic st(input int e);
    m_st = e;
    rd(ADDR_STATUS);
    chk(v[2:0], m_st, "state");
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? drv.ss_ramp_active : (s == 1 ? drv.hs_on : pco);
  endfunction
  // Length of a level, or of a full period when both is set
  task automatic meas(input int s, input logic lv, input logic both, output int n);
    int k;
    k = 0;
    n = 0;
    do begin
      @(negedge aclk);
      k++;
    end while (pick(s) !== lv && k < 3000);
    while (pick(s) === lv && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    while (both && pick(s) !== lv && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
  endtask
  task automatic period(input int s, output int n);
    meas(s, 1'b1, 1'b0, n);
    meas(s, 1'b1, 1'b1, n);
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #3000000;
    chk(0, 1, "timeout");
    conclude();
  end
  // ==========================================================
  // Scenarios
  initial begin
    v = $urandom(32'h0d6704b5);
    sn.loop_end_on = 1'b1;
    cyc(3);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(drv, 8'h08, "reset drive");
    chk({pokoe, pcoe}, 2'b10, "reset pins");
    @(posedge aclk);
    rd(8'h0c);
    chk(r, RESP_SLVERR, "unmapped resp");
    chk(v, 32'h0, "unmapped data");
    wr(ADDR_STATUS, $urandom);
    chk(r, RESP_OKAY, "ro write");
    st(0);
    sn.mode_sync <= 1'b1;
    for (f = 0; f < 2; f++) begin
      sn.en <= 1'b0;
      sn.bias_ok <= 1'b0;
      cyc(6);
      st(0);
      wr(ADDR_CTRL, f);
      rd(ADDR_CTRL);
      chk(v, f, "ctrl");
      sn.en <= 1'b1;
      cyc(8);
      st(1);
      chk(v[3], 1'b0, "controller");
      sn.bias_ok <= 1'b1;
      meas(0, 1'b1, 1'b0, h);
      chk(h, f ? SSH : SSL, "ramp");
      per = f ? PER_HIGH_CYC : PER_LOW_CYC;
      period(1, h);
      chk(h, per, "period");
      meas(2, 1'b1, 1'b0, h);
      meas(2, 1'b1, 1'b0, h);
      chk({h, pcoe, drv.shared_node_drive}, {per - per / 2, 2'b11}, "phase");
    end
    sn.out_above_2v5 <= 1'b1;
    cyc(6);
    chk(drv.bias_from_output, 1'b1, "bias out");
    sn.out_below_1v8 <= 1'b1;
    cyc(6);
    chk(drv.bias_from_output, 1'b0, "bias in");
    sn.out_in_window <= 1'b1;
    cyc(6);
    chk(pokoe, 1'b0, "power ok released");
    sn.light_load <= 1'b1;
    sn.mode_sync <= 1'b0;
    cyc(200);
    st(3);
    chk({v[5], drv.hs_on, pco}, 3'b100, "skip");
    sn.light_load <= 1'b0;
    period(1, h);
    chk(h, per, "skip period");
    sn.mode_sync <= 1'b1;
    run <= 1'b1;
    cyc(30);
    st(3);
    chk(v[4], 1'b1, "locked");
    period(1, h);
    chk(h, 8, "sync period");
    run <= 1'b0;
    cyc(140);
    st(3);
    chk(v[4], 1'b0, "unlocked");
    period(1, h);
    chk(h, per, "fallback period");
    sn.cur_limit <= 1'b1;
    cyc(6);
    // Align to a period start so the status read lands mid-period
    meas(1, 1'b1, 1'b0, h);
    st(3);
    @(negedge aclk);
    chk({v[8], drv.hs_on, drv.ls_on}, 3'b101, "limit");
    chk(h, 1, "limit on time");
    @(posedge aclk);
    sn.cur_limit <= 1'b0;
    meas(1, 1'b1, 1'b0, h);
    chk(h > 0, 1'b1, "high side back");
    sn.en <= 1'b0;
    sn.bias_ok <= 1'b0;
    sn.out_low_quarter <= 1'b1;
    sn.cur_limit <= 1'b1;
    cyc(6);
    sn.en <= 1'b1;
    sn.bias_ok <= 1'b1;
    meas(0, 1'b1, 1'b1, h);
    chk(h >= SSH + HIH && h <= SSH + HIH + 24, 1'b1, "hiccup");
    rd(ADDR_HICCUPS);
    chk(v, 1, "short count");
    sn.out_low_quarter <= 1'b0;
    sn.cur_limit <= 1'b0;
    sn.over_temp <= 1'b1;
    cyc(8);
    st(5);
    sn.over_temp <= 1'b0;
    cyc(8);
    st(5);
    sn.temp_cooled <= 1'b1;
    cyc(8);
    st(2);
    sn.over_temp <= 1'b1;
    cyc(8);
    sn.en <= 1'b0;
    cyc(6);
    st(0);
    chk(drv, 8'h08, "off drive");
    sn.over_temp <= 1'b0;
    tie <= 1'b1;
    sn.en <= 1'b1;
    cyc(8);
    st(2);
    chk({v[3], drv.shared_node_as_input, pcoe}, 3'b110, "target");
    conclude();
  end
endmodule
